// File: rtl/pcb_pkg.sv
// Package of constants and types for the PLL clock and boot select block
package pcb_pkg;

    // ==============================================================
    // PLL ratio fields
    localparam int R_W  = 6;
    localparam int F_W  = 12;
    localparam int OD_W = 3;

    // Strap preset table, indexed by the two PLL strap bits
    localparam logic [R_W-1:0]  PRE_REF [4] = '{6'h00, 6'h00, 6'h00, 6'h00};
    localparam logic [F_W-1:0]  PRE_FB  [4] = '{12'h07A, 12'h017, 12'h031, 12'h077};
    localparam logic [OD_W-1:0] PRE_OD  [4] = '{3'h1, 3'h2, 3'h2, 3'h2};

    // ==============================================================
    // Straps and boot
    localparam int          MODE_W        = 4;
    localparam logic [1:0]  STRAP_EDGES   = 2'h3;
    localparam int          SEC_BOOT_BIT  = 5;
    localparam int          OTP_ADDR_W    = 13;
    localparam logic [12:0] OTP_BOOT_ADDR = 13'h0000;
    localparam logic [1:0]  SRC_JTAG      = 2'h0;
    localparam logic [1:0]  SRC_RSVD      = 2'h1;
    localparam logic [1:0]  SRC_LINK_B    = 2'h2;
    localparam logic [1:0]  SRC_SPI       = 2'h3;

    // ==============================================================
    // SPI boot master
    localparam logic [7:0]  SPI_READ_CMD  = 8'h03;
    localparam logic [23:0] SPI_START_ADR = 24'h000000;
    localparam logic [4:0]  SPI_CMD_LAST  = 5'h1F;
    localparam logic [2:0]  SPI_BYTE_LAST = 3'h7;
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          SPI_CLK_NS    = 80;
    localparam int          SPI_HALF_CYC  =
        (SPI_CLK_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==============================================================
    // Reference clock and timers
    localparam int          TIMER_W       = 32;
    localparam int          TIMER_TICK_NS = 10;
    localparam int          CB_DIV_W      = 8;

    typedef enum logic [3:0] {
        ST_STRAP   = 4'h0,
        ST_LOCK    = 4'h1,
        ST_JTAG    = 4'h2,
        ST_RSVD    = 4'h3,
        ST_LINK    = 4'h4,
        ST_OTP     = 4'h5,
        ST_SPI_CMD = 4'h6,
        ST_SPI_DAT = 4'h7,
        ST_SPI_END = 4'h8
    } pcb_state_t;

endpackage

// File: rtl/pcb_cb_if.sv
// Interface between the top and one clock block
interface pcb_cb_if;
    logic                         use_ext;
    logic [pcb_pkg::CB_DIV_W-1:0] div;
    logic                         out_en;
    logic                         ext_pin;
    logic                         ref_tick;
    logic                         tick;
    logic                         pin_out;
    logic                         pin_oe;

    modport ctrl (output use_ext, div, out_en, ext_pin, ref_tick,
                  input tick, pin_out, pin_oe);
    modport blk  (input use_ext, div, out_en, ext_pin, ref_tick,
                  output tick, pin_out, pin_oe);
endinterface

// File: rtl/pcb_clock_block.sv
// One clock block: external pin or divided reference clock, optional pin output
module pcb_clock_block (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    pcb_cb_if.blk     cb
);
    logic                         ext_m_q;
    logic                         ext_s_q;
    logic                         ext_p_q;
    logic [pcb_pkg::CB_DIV_W-1:0] cnt_q;
    logic                         tick_q;
    logic                         pin_q;
    wire                          ext_rise = ext_s_q & ~ext_p_q;
    wire                          div_hit  = cb.ref_tick && (cnt_q == cb.div);

    // ==============================================================
    // External clock pin synchroniser and edge history
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_m_q <= 1'b0;
            ext_s_q <= 1'b0;
            ext_p_q <= 1'b0;
        end else if (clk_en) begin
            ext_m_q <= cb.ext_pin;
            ext_s_q <= ext_m_q;
            ext_p_q <= ext_s_q;
        end
    end

    // Divider on reference ticks, tick and pin toggle
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
            pin_q  <= 1'b0;
        end else if (clk_en) begin
            if (div_hit) begin
                cnt_q <= '0;
            end else if (cb.ref_tick) begin
                cnt_q <= cnt_q + 1'b1;
            end
            tick_q <= cb.use_ext ? ext_rise : div_hit; // RL16
            if (tick_q) begin
                pin_q <= ~pin_q;
            end
        end
    end

    assign cb.tick    = tick_q;
    assign cb.pin_out = pin_q & cb.out_en; // RL16
    assign cb.pin_oe  = cb.out_en;
endmodule

// File: rtl/pcb_top.sv
// PLL ratio control, clock tree ticks, clock blocks, timer and boot selection
// Overview of operation
// RL1: PLL preset comes from two straps at start-up; software may change it later.
// RL2: Tile clock is oscillator times (F+1)/2, over (R+1), over (OD+1).
// RL3: Programmer keeps R 0..63, F 0..4095, OD 0..7 and VCO 260 MHz..1.3 GHz.
// RL4: Software rewrites all three PLL ratio fields with one configuration write.
// RL5: Each of four PLL strap codes loads one fixed design-time preset.
// RL6: Board holds straps steady until third clock edge after reset release.
// RL7: Fast-grade boot software reprograms PLL since presets stop at 400 MHz.
// RL8: Upper straps select boot: 01 reserved, 10 link B, 11 SPI flash.
// RL9: Upper straps 00: load nothing, idle until code arrives through test port.
// RL10: Security bit 5 set overrides boot straps; boot from one-time memory.
// RL11: SPI boot master uses fixed pins: in 0, select 1, clock 10, out 11.
// RL12: Timer is a 32-bit counter advancing once per 10 ns reference tick.
// RL13: Reference clock derives from PLL output, 100 MHz unless reconfigured.
// RL14: Switch, tile and reference clocks all come from the PLL output.
// RL15: After reset every port uses clock block 0, driven from reference clock.
// RL16: Clock block runs from external pin or divided reference; may drive a pin.
// RL17: Each port samples and drives on its attached clock block's clock.
// RL18: Reset asserts asynchronously; after release wait PLL lock, then boot.
// RL19: One-time memory boot starts at its address 0, bypassing boot ROM.
// RL20: Boot and PLL straps latch once on third edge after reset release.
module pcb_top #(
    parameter int         NUM_CB          = 6,
    parameter int         NUM_PORTS       = 8,
    parameter int         CB_SEL_W        = 3,
    parameter int         PORT_IDX_W      = 3,
    parameter logic [7:0] REF_DIV_DEFAULT = 8'h04
) (
    input  wire logic                          ref_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          clk_en,
    input  wire logic [pcb_pkg::MODE_W-1:0]    mode_pins,
    input  wire logic                          pll_lock_pin,
    input  wire logic                          vco_tick,
    input  wire logic [31:0]                   security_reg,
    input  wire logic                          pll_cfg_wr,
    input  wire logic [pcb_pkg::R_W-1:0]       pll_cfg_ref_div,
    input  wire logic [pcb_pkg::F_W-1:0]       pll_cfg_fb,
    input  wire logic [pcb_pkg::OD_W-1:0]      pll_cfg_out_div,
    input  wire logic                          ref_div_wr,
    input  wire logic [7:0]                    ref_div_wdata,
    input  wire logic [NUM_CB-1:0]             cb_cfg_wr,
    input  wire logic                          cb_cfg_use_ext,
    input  wire logic [pcb_pkg::CB_DIV_W-1:0]  cb_cfg_div,
    input  wire logic                          cb_cfg_out_en,
    input  wire logic [NUM_CB-1:0]             cb_ext_clk_pin,
    output logic      [NUM_CB-1:0]             cb_clk_out_pin,
    output logic      [NUM_CB-1:0]             cb_clk_out_oe,
    input  wire logic                          port_attach_wr,
    input  wire logic [PORT_IDX_W-1:0]         port_attach_idx,
    input  wire logic [CB_SEL_W-1:0]           port_attach_cb,
    output logic      [NUM_PORTS-1:0]          port_tick,
    output logic      [pcb_pkg::R_W-1:0]       pll_ref_div,
    output logic      [pcb_pkg::F_W-1:0]       pll_fb,
    output logic      [pcb_pkg::OD_W-1:0]      pll_out_div,
    output logic      [12:0]                   pll_ratio_num,
    output logic      [11:0]                   pll_ratio_den,
    output logic                               switch_tick,
    output logic                               tile_tick,
    output logic                               ref_tick,
    output logic      [pcb_pkg::TIMER_W-1:0]   timer_value,
    output logic                               straps_latched,
    output logic      [1:0]                    boot_source,
    output logic      [3:0]                    boot_state,
    output logic                               boot_start,
    output logic                               boot_wait_jtag,
    output logic                               boot_reserved,
    output logic                               boot_link_b_en,
    output logic                               boot_from_otp,
    output logic      [pcb_pkg::OTP_ADDR_W-1:0] boot_addr,
    input  wire logic                          boot_data_in_pin,
    output logic                               boot_select_pin,
    output logic                               boot_select_oe,
    output logic                               boot_clock_pin,
    output logic                               boot_clock_oe,
    output logic                               boot_data_out_pin,
    output logic                               boot_data_out_oe,
    input  wire logic                          boot_spi_stop,
    output logic      [7:0]                    boot_byte,
    output logic                               boot_byte_valid
);
    // ==============================================================
    // Elaboration checks
    if (NUM_CB > (1 << CB_SEL_W) || NUM_CB < 1) begin : g_chk_cb
        $error("NUM_CB does not fit CB_SEL_W");
    end
    if (NUM_PORTS > (1 << PORT_IDX_W) || NUM_PORTS < 1) begin : g_chk_port
        $error("NUM_PORTS does not fit PORT_IDX_W");
    end
    if (REF_DIV_DEFAULT == 8'h00) begin : g_chk_ref
        $error("REF_DIV_DEFAULT must be nonzero");
    end

    // ==============================================================
    // Pin synchronisers
    logic [pcb_pkg::MODE_W-1:0] mode_m_q;
    logic [pcb_pkg::MODE_W-1:0] mode_s_q;
    logic                       lock_m_q;
    logic                       lock_s_q;
    logic                       din_m_q;
    logic                       din_s_q;

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mode_m_q <= '0;
            mode_s_q <= '0;
            lock_m_q <= 1'b0;
            lock_s_q <= 1'b0;
            din_m_q  <= 1'b0;
            din_s_q  <= 1'b0;
        end else if (clk_en) begin
            mode_m_q <= mode_pins;
            mode_s_q <= mode_m_q;
            lock_m_q <= pll_lock_pin;
            lock_s_q <= lock_m_q;
            din_m_q  <= boot_data_in_pin;
            din_s_q  <= din_m_q;
        end
    end

    // ==============================================================
    // Strap latch on the third edge after reset release
    logic [1:0] edge_cnt_q;
    logic       latched_q;
    logic [1:0] pll_strap_q;
    logic [1:0] src_strap_q;
    wire        latch_now = clk_en && !latched_q && (edge_cnt_q == pcb_pkg::STRAP_EDGES - 2'h1);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            edge_cnt_q  <= '0;
            latched_q   <= 1'b0;
            pll_strap_q <= '0;
            src_strap_q <= '0;
        end else if (latch_now) begin
            latched_q   <= 1'b1; // RL20
            pll_strap_q <= mode_s_q[1:0]; // RL6
            src_strap_q <= mode_s_q[3:2]; // RL20
        end else if (clk_en && !latched_q) begin
            edge_cnt_q <= edge_cnt_q + 2'h1;
        end
    end

    // ==============================================================
    // PLL ratio fields: preset at latch, software write afterwards
    logic [pcb_pkg::R_W-1:0]  r_q;
    logic [pcb_pkg::F_W-1:0]  f_q;
    logic [pcb_pkg::OD_W-1:0] od_q;
    wire  [1:0]               pre_idx = mode_s_q[1:0];

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            r_q  <= pcb_pkg::PRE_REF[0];
            f_q  <= pcb_pkg::PRE_FB[0];
            od_q <= pcb_pkg::PRE_OD[0];
        end else if (latch_now) begin
            r_q  <= pcb_pkg::PRE_REF[pre_idx]; // RL5
            f_q  <= pcb_pkg::PRE_FB[pre_idx]; // RL1
            od_q <= pcb_pkg::PRE_OD[pre_idx]; // RL5
        end else if (clk_en && pll_cfg_wr && latched_q) begin
            r_q  <= pll_cfg_ref_div; // RL4
            f_q  <= pll_cfg_fb; // RL4
            od_q <= pll_cfg_out_div; // RL7
        end
    end

    // Ratio as numerator over denominator
    assign pll_ref_div   = r_q;
    assign pll_fb        = f_q;
    assign pll_out_div   = od_q;
    assign pll_ratio_num = {1'b0, f_q} + 13'h0001; // RL2
    assign pll_ratio_den = 12'({r_q + 7'h01, 1'b0} * (od_q + 4'h1)); // RL2

    // ==============================================================
    // Clock tree: switch, tile and reference ticks from the VCO
    logic [pcb_pkg::OD_W-1:0] od_cnt_q;
    logic [7:0]               ref_cnt_q;
    logic [7:0]               ref_div_q;
    logic                     sw_q;
    logic                     tile_q;
    logic                     ref_q;
    logic [pcb_pkg::TIMER_W-1:0] timer_q;
    wire                      od_hit  = vco_tick && (od_cnt_q == od_q);
    wire                      ref_hit = vco_tick && (ref_cnt_q == ref_div_q - 8'h01);

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            od_cnt_q <= '0;
            tile_q   <= 1'b0;
            sw_q     <= 1'b0;
        end else if (clk_en) begin
            od_cnt_q <= od_hit ? '0 : od_cnt_q + (vco_tick ? 3'h1 : 3'h0);
            tile_q   <= od_hit; // RL14
            sw_q     <= vco_tick; // RL14
        end
    end

    // Reference divider, reconfigurable, and the timer it drives
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_div_q <= REF_DIV_DEFAULT;
            ref_cnt_q <= '0;
            ref_q     <= 1'b0;
            timer_q   <= '0;
        end else if (clk_en) begin
            if (ref_div_wr && ref_div_wdata != 8'h00) begin
                ref_div_q <= ref_div_wdata; // RL13
                ref_cnt_q <= '0;
            end else begin
                ref_cnt_q <= ref_hit ? '0 : ref_cnt_q + (vco_tick ? 8'h01 : 8'h00);
            end
            ref_q <= ref_hit; // RL13
            if (ref_q) begin
                timer_q <= timer_q + 32'h0000_0001; // RL12
            end
        end
    end

    assign switch_tick = sw_q;
    assign tile_tick   = tile_q;
    assign ref_tick    = ref_q;
    assign timer_value = timer_q;

    // ==============================================================
    // Clock blocks and port attachment
    logic [NUM_CB-1:0]   cb_tick;

    for (genvar c = 0; c < NUM_CB; c++) begin : g_cb
        pcb_cb_if                     cbi ();
        logic                         use_ext_q;
        logic [pcb_pkg::CB_DIV_W-1:0] div_q;
        logic                         out_en_q;

        // Block config, reset to the divided reference clock
        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                use_ext_q <= 1'b0; // RL15
                div_q     <= '0;
                out_en_q  <= 1'b0;
            end else if (clk_en && cb_cfg_wr[c]) begin
                use_ext_q <= cb_cfg_use_ext; // RL16
                div_q     <= cb_cfg_div;
                out_en_q  <= cb_cfg_out_en; // RL16
            end
        end

        assign cbi.use_ext   = use_ext_q;
        assign cbi.div       = div_q;
        assign cbi.out_en    = out_en_q;
        assign cbi.ext_pin   = cb_ext_clk_pin[c];
        assign cbi.ref_tick  = ref_q;
        assign cb_tick[c]        = cbi.tick;
        assign cb_clk_out_pin[c] = cbi.pin_out;
        assign cb_clk_out_oe[c]  = cbi.pin_oe;

        pcb_clock_block u_cb (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst),
            .clk_en  (clk_en),
            .cb      (cbi.blk)
        );
    end

    for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
        logic [CB_SEL_W-1:0] sel_q;
        // Attachment, reset to clock block 0
        always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
                sel_q <= '0; // RL15
            end else if (clk_en && port_attach_wr &&
                         port_attach_idx == PORT_IDX_W'(p) &&
                         port_attach_cb < CB_SEL_W'(NUM_CB)) begin
                sel_q <= port_attach_cb;
            end
        end
        assign port_tick[p] = cb_tick[sel_q]; // RL17
    end

    // ==============================================================
    // Boot sequencer
    pcb_pkg::pcb_state_t st_q;
    pcb_pkg::pcb_state_t st_d;
    logic                start_q;
    wire                 secure = security_reg[pcb_pkg::SEC_BOOT_BIT];
    wire                 spi_stop_ok;

    // Next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            pcb_pkg::ST_STRAP: begin
                if (latch_now) st_d = pcb_pkg::ST_LOCK;
            end
            pcb_pkg::ST_LOCK: begin
                if (lock_s_q) begin // RL18
                    if (secure) st_d = pcb_pkg::ST_OTP; // RL10
                    else if (src_strap_q == pcb_pkg::SRC_JTAG) st_d = pcb_pkg::ST_JTAG;
                    else if (src_strap_q == pcb_pkg::SRC_RSVD) st_d = pcb_pkg::ST_RSVD;
                    else if (src_strap_q == pcb_pkg::SRC_LINK_B) st_d = pcb_pkg::ST_LINK;
                    else st_d = pcb_pkg::ST_SPI_CMD; // RL8
                end
            end
            pcb_pkg::ST_SPI_CMD: begin
                if (spi_stop_ok) st_d = pcb_pkg::ST_SPI_DAT;
            end
            pcb_pkg::ST_SPI_DAT: begin
                if (spi_stop_ok) st_d = pcb_pkg::ST_SPI_END;
            end
            default: st_d = st_q;
        endcase
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q    <= pcb_pkg::ST_STRAP;
            start_q <= 1'b0;
        end else if (clk_en) begin
            st_q    <= st_d;
            start_q <= (st_q == pcb_pkg::ST_LOCK) && (st_d != pcb_pkg::ST_LOCK);
        end
    end

    assign straps_latched = latched_q;
    assign boot_source    = src_strap_q;
    assign boot_state     = st_q;
    assign boot_start     = start_q;
    assign boot_wait_jtag = (st_q == pcb_pkg::ST_JTAG); // RL9
    assign boot_reserved  = (st_q == pcb_pkg::ST_RSVD); // RL8
    assign boot_link_b_en = (st_q == pcb_pkg::ST_LINK); // RL8
    assign boot_from_otp  = (st_q == pcb_pkg::ST_OTP); // RL19
    assign boot_addr      = pcb_pkg::OTP_BOOT_ADDR; // RL19

    // ==============================================================
    // SPI boot master on fixed pins, mode 0, read from address 0
    logic [7:0]  half_q;
    logic        sclk_q;
    logic [31:0] sh_q;
    logic [4:0]  bit_q;
    logic [7:0]  rx_q;
    logic [7:0]  byte_q;
    logic        bv_q;
    wire         in_cmd  = (st_q == pcb_pkg::ST_SPI_CMD);
    wire         in_dat  = (st_q == pcb_pkg::ST_SPI_DAT);
    wire         half_w  = (half_q == 8'(pcb_pkg::SPI_HALF_CYC - 1));
    wire         rise    = (in_cmd || in_dat) && half_w && !sclk_q;
    wire         fall    = (in_cmd || in_dat) && half_w && sclk_q;
    wire         cmd_end = in_cmd && fall && (bit_q == pcb_pkg::SPI_CMD_LAST);
    wire         byte_end = in_dat && rise && (bit_q[2:0] == pcb_pkg::SPI_BYTE_LAST);
    assign spi_stop_ok = cmd_end || (in_dat && boot_spi_stop && !sclk_q);

    // Clock phase generator
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            half_q <= '0;
            sclk_q <= 1'b0;
        end else if (clk_en) begin
            half_q <= (half_w || !(in_cmd || in_dat)) ? '0 : half_q + 8'h01;
            sclk_q <= (in_cmd || in_dat) ? sclk_q ^ half_w : 1'b0;
        end
    end

    // Command shifter and receive byte assembly
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sh_q   <= '0;
            bit_q  <= '0;
            rx_q   <= '0;
            byte_q <= '0;
            bv_q   <= 1'b0;
        end else if (clk_en) begin
            bv_q <= byte_end;
            if (st_q == pcb_pkg::ST_LOCK) begin
                sh_q  <= {pcb_pkg::SPI_READ_CMD, pcb_pkg::SPI_START_ADR};
                bit_q <= '0;
            end else if (cmd_end) begin
                bit_q <= '0;
            end else if (in_cmd && fall) begin
                sh_q  <= {sh_q[30:0], 1'b0};
                bit_q <= bit_q + 5'h01;
            end else if (rise && in_dat) begin
                rx_q  <= {rx_q[6:0], din_s_q}; // RL11
                bit_q <= bit_q + 5'h01;
                if (byte_end) begin
                    byte_q <= {rx_q[6:0], din_s_q};
                end
            end
        end
    end

    // Fixed pin drive while the SPI boot runs
    assign boot_select_pin   = !(in_cmd || in_dat); // RL11
    assign boot_select_oe    = in_cmd || in_dat || (st_q == pcb_pkg::ST_SPI_END);
    assign boot_clock_pin    = sclk_q; // RL11
    assign boot_clock_oe     = boot_select_oe;
    assign boot_data_out_pin = in_cmd && sh_q[31]; // RL11
    assign boot_data_out_oe  = boot_select_oe;
    assign boot_byte         = byte_q;
    assign boot_byte_valid   = bv_q;
endmodule

// File: bench/pcb_chk.sv
// Checker of straps, PLL fields, boot path and timer at the top ports
module pcb_chk (
    input wire logic        ref_clk, sys_rst, clk_en, straps_latched, ref_tick, boot_start,
    input wire logic        boot_from_otp, boot_select_pin, boot_select_oe,
    input wire logic [1:0]  boot_source,
    input wire logic [2:0]  pll_out_div,
    input wire logic [3:0]  mode_pins, boot_state,
    input wire logic [5:0]  pll_ref_div,
    input wire logic [11:0] pll_fb, pll_ratio_den,
    input wire logic [12:0] pll_ratio_num, boot_addr,
    input wire logic [31:0] security_reg, timer_value
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // =========
    // Lock wait ends
    sequence s_leave;
        boot_state == pcb_pkg::ST_LOCK ##1 boot_state != pcb_pkg::ST_LOCK;
    endsequence
    a_preset_load: assert property ($rose(straps_latched) |->
        pll_fb == pcb_pkg::PRE_FB[$past(mode_pins[1:0])]) else $error("bad preset");
    a_source_latch: assert property ($rose(straps_latched) |->
        boot_source == $past(mode_pins[3:2])) else $error("bad source");
    a_latch_held: assert property (straps_latched |=> straps_latched) else $error("lost");
    a_ratio_form: assert property (pll_ratio_num == pll_fb + 1 &&
        pll_ratio_den == 2 * (pll_ref_div + 1) * (pll_out_div + 1)) else $error("bad ratio");
    a_start_pulse: assert property (s_leave |-> ##[0:1] boot_start) else $error("no start");
    a_otp_boot: assert property (s_leave ##0 security_reg[5] |->
        boot_from_otp && boot_addr == 13'h0000) else $error("no otp boot");
    a_spi_select: assert property (boot_state == pcb_pkg::ST_SPI_CMD |->
        !boot_select_pin && boot_select_oe) else $error("no select");
    a_timer_step: assert property (ref_tick && clk_en |=>
        timer_value == $past(timer_value) + 1) else $error("bad timer");
endmodule
bind pcb_top pcb_chk chk_u (.*);

// File: bench/pcb_flash.sv
// Serial boot flash model: takes a 32-bit read, returns bytes 3C, 3D and up
module pcb_flash (
    input wire logic   sel_n, sck, mosi,
    output logic       miso = 1'h0,
    output logic [31:0] cmd
);
    timeunit 1ns / 1ns;
    int n;
    logic [7:0] v;
    // =========
    // Shift in on rising clock, answer on falling, invert when released
    always @(negedge sel_n) n = 0;
    always @(posedge sck) if (!sel_n) begin
        if (n < 32) cmd <= {cmd[30:0], mosi};
        n <= n + 1;
    end
    always @(negedge sck) if (!sel_n && n >= 32) begin
        v = 8'h3C + 8'((n - 32) / 8);
        miso <= v[7 - (n - 32) % 8];
    end
    always @(posedge sel_n) miso <= ~miso;
endmodule

// File: bench/pll_clock_and_boot_select_bench.sv
// Bench: strap boots, flash read, PLL write, timer and clock block ticks
module pll_clock_and_boot_select_bench;
    timeunit 1ns / 1ns;
    logic ref_clk = 0, sys_rst = 1, clk_en = 1, pll_lock_pin = 0, vco_tick = 1, pll_cfg_wr = 0;
    logic ref_div_wr = 0, cb_cfg_use_ext = 0, cb_cfg_out_en = 0, port_attach_wr = 0;
    logic boot_spi_stop = 0, boot_data_in_pin, straps_latched, ref_tick, switch_tick, tile_tick;
    logic boot_start, boot_wait_jtag, boot_reserved, boot_link_b_en, boot_from_otp;
    logic boot_byte_valid, boot_select_pin, boot_select_oe, boot_clock_pin, boot_clock_oe;
    logic boot_data_out_pin, boot_data_out_oe;
    logic [1:0] boot_source;
    logic [2:0] pll_cfg_out_div = 0, pll_out_div, port_attach_idx = 0, port_attach_cb = 0;
    logic [3:0] mode_pins = 0, boot_state, f;
    logic [5:0] pll_cfg_ref_div = 0, pll_ref_div, cb_cfg_wr = 0, cb_ext_clk_pin = 0;
    logic [5:0] cb_clk_out_pin, cb_clk_out_oe;
    logic [7:0] ref_div_wdata = 0, cb_cfg_div = 0, boot_byte, port_tick, n0, n2;
    logic [11:0] pll_cfg_fb = 0, pll_fb, pll_ratio_den;
    logic [12:0] pll_ratio_num, boot_addr;
    logic [31:0] security_reg = 0, timer_value, cmd, t0;
    int fail_count = 0, tests_run = 0;
    always #4 ref_clk = ~ref_clk;
    pcb_top dut_u (.*);
    pcb_flash flash_u (.sel_n(boot_select_pin), .sck(boot_clock_pin), .mosi(boot_data_out_pin),
        .miso(boot_data_in_pin), .cmd(cmd));
    // =========
    // Compare and count, report and stop, bounded wait on latch, start or byte
    task chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) fail_count++;
        if (seen !== exp) $display("BAD %s expected %h seen %h", nm, exp, seen);
    endtask
    task test_done;
        $display("mismatches %0d comparisons %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task wt(input logic [2:0] k);
        for (int i = 0; i < 2000; i++) begin
            @(negedge ref_clk);
            if (({straps_latched, boot_start, boot_byte_valid} & k) === k) return;
        end
        fail_count++;
        test_done();
    endtask
    // Reset with given straps, latch them, then report lock and check the boot path
    task boot(input logic [3:0] m, input logic s);
        f = s ? 4'h1 : m[3:2] == 2'h3 ? 4'h0 : 4'h8 >> m[3:2];
        sys_rst = 1; pll_lock_pin = 0; mode_pins = m; security_reg = {26'h0, s, 5'h00};
        repeat (8) @(negedge ref_clk);
        sys_rst = 0;
        wt(3'h4);
        chk("preset", {pll_ref_div, pll_fb, pll_out_div}, {pcb_pkg::PRE_REF[m[1:0]],
            pcb_pkg::PRE_FB[m[1:0]], pcb_pkg::PRE_OD[m[1:0]]});
        mode_pins = ~m; pll_lock_pin = 1;
        wt(3'h2);
        chk("boot", {boot_source, boot_wait_jtag, boot_reserved,
            boot_link_b_en, boot_from_otp, boot_select_oe, boot_clock_oe, boot_data_out_oe},
            {m[3:2], f, {3{f == 4'h0}}});
    endtask
    // Every boot source and preset, secure boot, flash read, then PLL and clock blocks
    initial begin
        for (int m = 0; m < 3; m++) boot(4'(m * 5), 1'b0);
        boot(4'hF, 1'b1);
        boot(4'hF, 1'b0);
        wt(3'h1);
        chk("byte0", boot_byte, 8'h3C);
        wt(3'h1);
        chk("byte1", boot_byte, 8'h3D);
        chk("cmd", cmd, {pcb_pkg::SPI_READ_CMD, pcb_pkg::SPI_START_ADR});
        boot_spi_stop = 1; pll_cfg_ref_div = 6'h01; pll_cfg_fb = 12'h0F9; pll_cfg_wr = 1;
        @(negedge ref_clk);
        pll_cfg_wr = 0; cb_cfg_wr = 6'h02; cb_cfg_div = 8'h01; cb_cfg_out_en = 1;
        port_attach_wr = 1; port_attach_idx = 3'h2; port_attach_cb = 3'h1;
        chk("pll", {pll_ref_div, pll_fb, pll_out_div}, {6'h01, 12'h0F9, 3'h0});
        @(negedge ref_clk);
        cb_cfg_wr = 0; port_attach_wr = 0; n0 = 0; n2 = 0;
        repeat (8) @(negedge ref_clk);
        t0 = timer_value;
        repeat (40) begin @(negedge ref_clk); n0 += port_tick[0]; n2 += port_tick[2]; end
        chk("timer", timer_value - t0, 32'h0000000A);
        chk("ticks", {n0, n2, cb_clk_out_oe}, {8'h0A, 8'h05, 6'h02});
        test_done();
    end
endmodule
